// >>> pkg/otg_info_pkg.sv
// package: register codes, field layouts and reset values of the limit/info bank
package otg_info_pkg;

    // ------------------------------------------------------------
    // register command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_INFO = 8'h3A;
    localparam logic [7:0] CMD_OTG_LIMIT = 8'h4A;

    // ------------------------------------------------------------
    // current-limit field layout
    // ------------------------------------------------------------
    localparam int LIMIT_LSB = 7;
    localparam int LIMIT_MSB = 12;
    localparam logic [5:0] LIMIT_MAX = 6'h20;
    localparam logic [5:0] LIMIT_RESET = 6'h00;

    // ------------------------------------------------------------
    // information field layout
    // ------------------------------------------------------------
    localparam int INFO_STRAP_LSB = 0;
    localparam int INFO_TRICKLE = 4;
    localparam int INFO_MODE_LSB = 5;
    localparam int INFO_STATE_LSB = 7;
    localparam int INFO_LOWRAIL = 10;
    localparam int INFO_DISCH = 11;
    localparam int INFO_ADAPT = 12;
    localparam int INFO_LOOP_LSB = 13;
    localparam int INFO_REF = 15;
    localparam logic [3:0] STRAP_RESET = 4'h0;
    localparam logic [15:0] INFO_RESET = 16'h0000;

    // ------------------------------------------------------------
    // status encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_BUCK = 2'h0,
        MODE_BOOST = 2'h1,
        MODE_BUCK_BOOST = 2'h2,
        MODE_REVERSE_BUCK = 2'h3
    } stage_mode_t;

    typedef enum logic [1:0] {
        LOOP_SYSTEM_VOLTAGE_CEILING = 2'h0,
        LOOP_CHARGE_CURRENT = 2'h1,
        LOOP_ADAPTER_CURRENT = 2'h2,
        LOOP_INPUT_VOLTAGE = 2'h3
    } reg_loop_t;

    // state codes: 1 battery, 2 adapter, 3 adapter_good_state,
    // 4 system_rail, 5 charge, 6 reverse_enable_state, 7 reverse output
    typedef struct packed {
        logic ref_active;
        reg_loop_t loop;
        logic adapter_current_hot_flag;
        logic battery_discharge_hot_flag;
        logic low_rail_hot_flag;
        logic [2:0] fsm_state;
        stage_mode_t mode;
        logic trickle;
    } live_status_t;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] cmd;
        logic [15:0] wdata;
    } reg_req_t;

endpackage : otg_info_pkg

// >>> hw/limit_clamp.sv
// module: keeps the valid current-limit bits and clamps to the maximum
`timescale 1ns/10ps
module limit_clamp (
    // raw written word
    input wire logic [15:0] word_in,
    // stored field value
    output logic [5:0] field_out
);
    logic [5:0] raw;

    assign raw = word_in[otg_info_pkg::LIMIT_MSB:otg_info_pkg::LIMIT_LSB];

    // bit 12 carries 4096 mA; any lower bit with it exceeds the ceiling
    always_comb begin
        if (raw > otg_info_pkg::LIMIT_MAX) begin
            field_out = otg_info_pkg::LIMIT_MAX;
        end else begin
            field_out = raw;
        end
    end
endmodule : limit_clamp

// >>> hw/pin_sync3.sv
// module: three-flop synchroniser with second/third agreement
`timescale 1ns/10ps
module pin_sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // asynchronous input and its settled copy
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a bit changes only once the two later stages agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_agree
            always_ff @(posedge clock) begin
                if (rst) begin
                    sync_out[i] <= 1'b0;
                end else if (s2_r[i] == s3_r[i]) begin
                    sync_out[i] <= s3_r[i];
                end
            end
        end
    endgenerate
endmodule : pin_sync3

// >>> hw/otg_limit_and_info_regs.sv
// module: reverse output current-limit register and information register
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Summary of operation
// - write word at 0x4A stores limit
// - keep only bits 12 to 7
// - clamp stored limit at 4096 mA
// - limit bits are binary weighted 128 mA up
// - information register readable at 0x3A
// - bits 3:0 report strap configuration
// - battery only: strap valid after monitor sampling
// - strap codes map to fixed combinations
// - bit 4 shows trickle charging
// - bits 6:5 show power stage mode
// - bits 9:7 show state machine state
// - bit 10 shows low rail hot flag
// - bit 11 shows discharge hot flag
// - bit 12 shows adapter current hot flag
// - bits 14:13 show active regulation loop
// - bit 15 shows reference active
// ----------------------------------------------------------------
module otg_limit_and_info_regs (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register access from the protocol engine (same clock)
    input wire otg_info_pkg::reg_req_t req,
    output logic [15:0] rdata,
    output logic rvalid,
    output logic ack,
    // strap sampling
    input wire logic [3:0] config_strap_pin,
    input wire logic strap_sample,
    input wire logic adapter_present,
    input wire logic system_power_monitor,
    // live status from the analog control (asynchronous)
    input wire otg_info_pkg::live_status_t live_status,
    // stored limit toward the regulation loop
    output logic [5:0] reverse_output_current_limit
);

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    localparam int LW = $bits(otg_info_pkg::live_status_t);

    logic [LW-1:0] status_sync;
    logic [6:0] ctrl_sync;
    logic [3:0] strap_s;
    logic sample_s;
    logic adapter_s;
    logic monitor_s;
    otg_info_pkg::live_status_t st;

    pin_sync3 #(.W(LW)) u_status_sync (
        .clock(clock),
        .rst(rst),
        .async_in(live_status),
        .sync_out(status_sync)
    );

    pin_sync3 #(.W(7)) u_ctrl_sync (
        .clock(clock),
        .rst(rst),
        .async_in({config_strap_pin, strap_sample, adapter_present,
                   system_power_monitor}),
        .sync_out(ctrl_sync)
    );

    assign st = otg_info_pkg::live_status_t'(status_sync);
    assign strap_s = ctrl_sync[6:3];
    assign sample_s = ctrl_sync[2];
    assign adapter_s = ctrl_sync[1];
    assign monitor_s = ctrl_sync[0];

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hits(input logic [7:0] cmd,
                                  input logic [7:0] code);
        hits = (cmd == code);
    endfunction : hits

    logic wr_limit;
    logic rd_limit;
    logic rd_info;

    assign wr_limit = req.wr_en && hits(req.cmd, otg_info_pkg::CMD_OTG_LIMIT);
    assign rd_limit = req.rd_en && hits(req.cmd, otg_info_pkg::CMD_OTG_LIMIT);
    assign rd_info = req.rd_en && hits(req.cmd, otg_info_pkg::CMD_INFO);

    // ------------------------------------------------------------
    // current-limit register
    // ------------------------------------------------------------
    logic [5:0] limit_nxt;
    logic [5:0] limit_r;

    limit_clamp u_clamp (
        .word_in(req.wdata),
        .field_out(limit_nxt)
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            limit_r <= otg_info_pkg::LIMIT_RESET;
        end else if (wr_limit) begin
            limit_r <= limit_nxt;
        end
    end

    assign reverse_output_current_limit = limit_r;

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    // with an adapter the strap is taken on every sample pulse; on battery alone the
    // strap is only measured while the power monitor is enabled
    logic [3:0] strap_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            strap_r <= otg_info_pkg::STRAP_RESET;
        end else if (sample_s && (adapter_s || monitor_s)) begin
            strap_r <= strap_s;
        end
    end

    // ------------------------------------------------------------
    // information word
    // ------------------------------------------------------------
    logic [15:0] info_word;

    always_comb begin
        info_word = otg_info_pkg::INFO_RESET;
        info_word[otg_info_pkg::INFO_STRAP_LSB +: 4] = strap_r;
        info_word[otg_info_pkg::INFO_TRICKLE] = st.trickle;
        info_word[otg_info_pkg::INFO_MODE_LSB +: 2] = st.mode;
        info_word[otg_info_pkg::INFO_STATE_LSB +: 3] = st.fsm_state;
        info_word[otg_info_pkg::INFO_LOWRAIL] =
            st.low_rail_hot_flag;
        info_word[otg_info_pkg::INFO_DISCH] =
            st.battery_discharge_hot_flag;
        info_word[otg_info_pkg::INFO_ADAPT] =
            st.adapter_current_hot_flag;
        info_word[otg_info_pkg::INFO_LOOP_LSB +: 2] = st.loop;
        info_word[otg_info_pkg::INFO_REF] = st.ref_active;
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // unmapped reads return zero; writes to 0x3A have no target at all
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (rd_info) begin
            rdata <= info_word;
        end else if (rd_limit) begin
            rdata <= {3'h0, limit_r, 7'h00};
        end else if (req.rd_en) begin
            rdata <= 16'h0000;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd_en;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= req.wr_en || req.rd_en;
        end
    end

endmodule : otg_limit_and_info_regs

// >>> tb/otg_limit_and_info_regs_sva.sv
// checker: port relations of the limit/info register bank
`timescale 1ns/10ps
module otg_limit_and_info_regs_sva (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register access
    input wire otg_info_pkg::reg_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic ack,
    // status inputs and stored limit
    input wire otg_info_pkg::live_status_t live_status,
    input wire logic [5:0] reverse_output_current_limit
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // status must sit still long enough to cross the synchroniser
    otg_info_pkg::live_status_t prev_r;
    logic [3:0] stab_r;
    logic lim_wr;
    logic any_req;
    logic info_rd;
    logic [5:0] lim;
    assign any_req = req.wr_en || req.rd_en;
    assign info_rd = req.rd_en && req.cmd == 8'h3A && stab_r >= 4'h6;
    assign lim_wr = req.wr_en && req.cmd == 8'h4A;
    assign lim = reverse_output_current_limit;
    always_ff @(posedge clock) prev_r <= live_status;
    always_ff @(posedge clock) begin
        if (rst || live_status != prev_r) stab_r <= 4'h0;
        else if (stab_r != 4'hF) stab_r <= stab_r + 4'h1;
    end
    AST_ACK_PULSE: assert property (any_req |=> ack)
        else $error("ack missing after request");
    AST_ACK_QUIET: assert property (!any_req |=> !ack)
        else $error("ack without request");
    AST_RVALID: assert property (req.rd_en |=> rvalid)
        else $error("rvalid missing after read");
    AST_LIMIT_WRITE: assert property (lim_wr |=>
        lim == ($past(req.wdata[12]) ? 6'h20 : $past(req.wdata[12:7])))
        else $error("stored limit wrong");
    AST_LIMIT_HOLD: assert property (!lim_wr |=> $stable(lim))
        else $error("limit changed without write");
    AST_LIMIT_MAX: assert property (lim <= 6'h20)
        else $error("limit above maximum");
    AST_LIMIT_READ: assert property (req.rd_en && !req.wr_en &&
        req.cmd == 8'h4A |=> rdata == {3'h0, $past(lim), 7'h00})
        else $error("limit readback wrong");
    AST_UNMAPPED: assert property (req.rd_en && req.cmd != 8'h3A &&
        req.cmd != 8'h4A |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_INFO_MODE: assert property (info_rd |=>
        rdata[9:4] == $past(live_status[5:0]))
        else $error("info mode or state bits wrong");
    AST_INFO_HOT: assert property (info_rd |=>
        rdata[12:10] == $past(live_status[8:6]))
        else $error("info hot flag bits wrong");
    AST_INFO_LOOP: assert property (info_rd |=>
        rdata[15:13] == $past(live_status[11:9]))
        else $error("info loop or reference bits wrong");
    AST_RDATA_HOLD: assert property (!req.rd_en |=> $stable(rdata))
        else $error("rdata changed without read");
    COV_WRITE: cover property (lim_wr ##1 ack);
    COV_INFO: cover property (req.rd_en && req.cmd == 8'h3A ##1 rvalid);
    COV_CLAMP: cover property (lim_wr && req.wdata[12] && req.wdata[7]);
endmodule : otg_limit_and_info_regs_sva
bind otg_limit_and_info_regs otg_limit_and_info_regs_sva
    otg_limit_and_info_regs_sva_inst (.clock, .rst, .req, .rdata, .rvalid,
    .ack, .live_status, .reverse_output_current_limit);

// >>> tb/host_model.sv
// partner: register host issuing one word per request
`timescale 1ns/10ps
module host_model (
    // clock
    input wire logic clock,
    // bus toward the register bank
    output otg_info_pkg::reg_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic ack
);
    initial req = '0;
    task automatic xfer(input logic wr, input logic [7:0] cmd,
        input logic [15:0] wd, output logic [15:0] rd, output logic ok);
        @(negedge clock);
        req = '{wr_en: wr, rd_en: !wr, cmd: cmd, wdata: wd};
        @(negedge clock);
        ok = (ack === 1'b1) && (wr || rvalid === 1'b1);
        rd = rdata;
        // released lines show inverted values, not the last ones
        req = '{wr_en: 1'b0, rd_en: 1'b0, cmd: ~cmd, wdata: ~wd};
    endtask : xfer
endmodule : host_model

// >>> tb/tb_top.sv
// testbench: random and corner checks of the limit/info register bank
`timescale 1ns/10ps
module tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] config_strap_pin = 4'h0;
    logic strap_sample = 1'b0;
    logic adapter_present = 1'b0;
    logic system_power_monitor = 1'b0;
    otg_info_pkg::live_status_t live_status = '0;
    otg_info_pkg::reg_req_t req;
    logic [15:0] rdata, rd, w;
    logic rvalid, ack, ok;
    logic [5:0] lim;
    logic [11:0] s;
    logic [15:0] e;
    int err_count = 0;
    int n_compared = 0;
    localparam logic [15:0] CORNER [5] = '{16'h1F80, 16'hFFFF, 16'h0F80,
        16'h1000, 16'h007F};
    always #50 clock = ~clock;
    otg_limit_and_info_regs otg_limit_and_info_regs_inst (.clock, .rst,
        .req, .rdata, .rvalid, .ack, .config_strap_pin, .strap_sample,
        .adapter_present, .system_power_monitor, .live_status,
        .reverse_output_current_limit(lim));
    host_model host_model_inst (.clock, .req, .rdata, .rvalid, .ack);
    function automatic logic [15:0] exp_lim(input logic [15:0] wd);
        return {3'h0, wd[12] ? 6'h20 : wd[12:7], 7'h00};
    endfunction : exp_lim
    task automatic rw(input logic wr, input logic [7:0] c,
        input logic [15:0] d);
        host_model_inst.xfer(wr, c, d, rd, ok);
    endtask : rw
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp || ok !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic strap(input logic [3:0] p, input logic [2:0] ctl);
        @(negedge clock);
        config_strap_pin = p;
        {strap_sample, adapter_present, system_power_monitor} = ctl;
        repeat (6) @(negedge clock);
        rw(1'b0, 8'h3A, 16'h0000);
    endtask : strap
    task automatic results;
        $display("mismatches %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    initial begin
        #(20000 * 100);
        err_count++;
        results();
    end
    initial begin
        void'($urandom(32'h500E));
        repeat (2) @(negedge clock);
        rst = 1'b0;
        rw(1'b0, 8'h4A, 16'h0000);
        check(rd, 16'h0000);
        for (int i = 0; i < 24; i++) begin
            w = (i < 5) ? CORNER[i] : 16'($urandom());
            rw(1'b1, 8'h4A, w);
            check({3'h0, lim, 7'h00}, exp_lim(w));
            rw(1'b0, 8'h4A, 16'h0000);
            check(rd, exp_lim(w));
        end
        rw(1'b1, 8'h3A, 16'hFFFF);
        rw(1'b0, 8'h4A, 16'h0000);
        check(rd, exp_lim(w));
        rw(1'b0, 8'h00, 16'h0000);
        check(rd, 16'h0000);
        rw(1'b0, 8'hFF, 16'h0000);
        check(rd, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            s = 12'($urandom());
            {s[10:9], s[2:1]} = i[3:0];
            s[5:3] = 3'(i);
            @(negedge clock);
            live_status = s;
            repeat (6) @(negedge clock);
            rw(1'b0, 8'h3A, 16'h0000);
            e = {s, 4'h0};
            check(rd & 16'h03FF, e & 16'h03FF);
            check(rd & 16'h1C00, e & 16'h1C00);
            check(rd & 16'hE000, e & 16'hE000);
            rw(1'b0, 8'h3A, 16'h0000);
            check(rd, {s, 4'h0});
        end
        // battery only: sample seen but monitor off keeps old code
        strap(4'h6, 3'b100);
        check(rd, {s, 4'h0});
        strap(4'h6, 3'b101);
        check(rd, {s, 4'h6});
        strap(4'hA, 3'b110);
        check(rd, {s, 4'hA});
        strap(4'hF, 3'b110);
        check(rd, {s, 4'hF});
        strap(4'h3, 3'b010);
        check(rd, {s, 4'hF});
        results();
    end
endmodule : tb_top
